//--- dac_latch_pkg.sv
// Purpose: shared constants and types for the serial converter latch
// Assumes: one 10 MHz system clock, link pins sampled as plain inputs
// Notes:   times are kept in their own unit and turned into cycles here
`default_nettype none
package dac_latch_pkg;
  localparam int unsigned WORD_W       = 16;        // sample width
  localparam int unsigned CNT_W        = 5;         // bit counter width
  localparam logic [4:0]  LAST_BIT     = 5'h10;     // sixteen bits taken
  localparam logic [15:0] MIDCODE      = 16'h0000;  // zero volts, two's c.
  localparam logic [15:0] CODE_POS_FS  = 16'h7fff;  // positive full scale
  localparam logic [15:0] CODE_NEG_FS  = 16'h8000;  // negative full scale
  localparam int unsigned CLK_HZ       = 10_000_000;
  localparam int unsigned UPDATE_NS    = 1000;      // update to output, 1 us
  // least time rounds up, never below one cycle
  localparam int unsigned UPDATE_CYC_I =
    (UPDATE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
  localparam logic [7:0]  UPDATE_CYC   =
    8'((UPDATE_CYC_I < 1) ? 1 : UPDATE_CYC_I);
  localparam int unsigned SYNC_N       = 3;         // pin synchroniser depth

  // link pins kept together
  typedef struct packed {
    logic select_n;        // chip select, active low
    logic bit_clk;         // serial bit clock
    logic serial_data_in;  // serial data
  } link_s;

  // frame sequencer states, one-hot
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,     // deselected
    ST_SHIFT = 3'b010,     // taking bits
    ST_DONE  = 3'b100      // latched, ignore clocks until deselect
  } frame_e;
endpackage
`default_nettype wire

//--- dac_input_latch.sv
// Purpose: serial front end and converter latch of a 16-bit converter
// Assumes: link pins are asynchronous, sampled by clk
// Notes:   bit clock must stay well below clk/6 for edges to be seen
//
// Operation
// [R01] 16-bit two's complement word, MSB first
// [R02] received word goes into converter latch
// [R03] latch code drives output, two's complement
// [R04] host waits after select before clocking
// [R05] host keeps select high between frames
// [R06] host waits after last edge before reselecting
// [R07] output settles one microsecond after update
// [R08] shift data on rising edge while selected
// [R09] latch on falling edge after sixteenth
// [R10] early deselect discards partial word
// [R11] clear low at update loads midcode
// [R12] reset puts midcode into latch
`default_nettype none
module dac_input_latch
  import dac_latch_pkg::*;
(
  input  wire logic              clk,             // 10 MHz system clock
  input  wire logic              rst_n,           // async, active low
  input  wire logic              select_n,        // chip select pin
  input  wire logic              bit_clk,         // serial bit clock pin
  input  wire logic              serial_data_in,  // serial data pin
  input  wire logic              force_midcode_n, // clear pin, active low
  output logic [WORD_W-1:0]      latch_code,      // converter latch
  output logic                   latch_update,    // one-cycle load pulse
  output logic                   output_settled   // output has settled
);

  // three-stage synchronisers; stage 0 feeds only stage 1
  link_s      s0_r, s1_r, s2_r;
  logic       clr0_r, clr1_r, clr2_r;  // clear pin chain
  link_s      lnk_r;                   // debounced link view
  logic       clr_r;                   // debounced clear view
  frame_e     state_r;                 // frame sequencer
  logic [WORD_W-1:0] shift_r;          // input shift register
  logic [CNT_W-1:0]  cnt_r;            // rising edges counted
  logic [7:0]        settle_r;         // update-to-output counter

  // sample pins into the clock domain
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s0_r   <= '{select_n: 1'b1, bit_clk: 1'b0, serial_data_in: 1'b0};
      s1_r   <= '{select_n: 1'b1, bit_clk: 1'b0, serial_data_in: 1'b0};
      s2_r   <= '{select_n: 1'b1, bit_clk: 1'b0, serial_data_in: 1'b0};
      clr0_r <= 1'b1;
      clr1_r <= 1'b1;
      clr2_r <= 1'b1;
    end else begin
      s0_r   <= '{select_n: select_n, bit_clk: bit_clk,
                  serial_data_in: serial_data_in};
      s1_r   <= s0_r;
      s2_r   <= s1_r;
      clr0_r <= force_midcode_n;
      clr1_r <= clr0_r;
      clr2_r <= clr1_r;
    end
  end

  // a change counts only once stages 1 and 2 agree
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lnk_r <= '{select_n: 1'b1, bit_clk: 1'b0, serial_data_in: 1'b0};
      clr_r <= 1'b1;
    end else begin
      if (s1_r.select_n == s2_r.select_n)
        lnk_r.select_n <= s2_r.select_n;
      if (s1_r.bit_clk == s2_r.bit_clk)
        lnk_r.bit_clk <= s2_r.bit_clk;
      if (s1_r.serial_data_in == s2_r.serial_data_in)
        lnk_r.serial_data_in <= s2_r.serial_data_in;
      if (clr1_r == clr2_r)
        clr_r <= clr2_r;
    end
  end

  // edge detection on the filtered bit clock
  logic clk_prev_r;  // last filtered bit clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      clk_prev_r <= 1'b0;
    else
      clk_prev_r <= lnk_r.bit_clk;
  end

  logic rise, fall, selected;
  assign rise     = lnk_r.bit_clk & ~clk_prev_r;
  assign fall     = ~lnk_r.bit_clk & clk_prev_r;
  assign selected = ~lnk_r.select_n;

  // data passes the same filter stages as the clock view, so sample the filtered data
  // taken with the clock; setup at the pin keeps it stable here
  logic load_now;    // falling edge after the sixteenth rise
  assign load_now = (state_r == ST_SHIFT) && selected && fall &&
                    (cnt_r == LAST_BIT);  // [R09]

  // frame sequencer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE:  if (selected) state_r <= ST_SHIFT;
        ST_SHIFT: begin
          if (!selected)
            state_r <= ST_IDLE;  // partial word dropped [R10]
          else if (load_now)
            state_r <= ST_DONE;  // [R09]
        end
        ST_DONE:  if (!selected) state_r <= ST_IDLE;  // clocks ignored [R09]
        default:  state_r <= ST_IDLE;
      endcase
    end
  end

  // a finished frame must not move the latch again, however long the
  // host keeps clocking; only a fresh select starts another word
  done_ignore_a: assert property (@(posedge clk)  // [R09]
    disable iff (!rst_n) (state_r == ST_DONE) |=> $stable(latch_code))
    else $error("latch moved after the frame was done");

  // early deselect returns to idle with the latch untouched
  deselect_drop_a: assert property (@(posedge clk)  // [R10]
    disable iff (!rst_n)
    (state_r == ST_SHIFT && !selected) |=> state_r == ST_IDLE
      && $stable(latch_code))
    else $error("partial word not discarded");

  // shift register and bit count, MSB first
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_r <= '0;
      cnt_r   <= '0;
    end else if (state_r != ST_SHIFT || !selected) begin
      cnt_r   <= '0;  // deselect or idle restarts the count [R08]
    end else if (rise && cnt_r != LAST_BIT) begin
      shift_r <= {shift_r[WORD_W-2:0], lnk_r.serial_data_in};  // [R01] [R08]
      cnt_r   <= cnt_r + 5'h01;
    end
  end

  // a load never comes before sixteen rising edges
  // were counted in this frame
  sixteen_bits_a: assert property (@(posedge clk)  // [R09]
    disable iff (!rst_n) load_now |-> cnt_r == LAST_BIT)
    else $error("load before sixteen bits");

  // nothing is counted while the select pin is high,
  // so stray clocks between frames cannot pre-load bits
  shift_idle_a: assert property (@(posedge clk)  // [R08]
    disable iff (!rst_n) !selected |=> cnt_r == 5'h00)
    else $error("bits counted while deselected");

  // converter latch; midcode at reset and on clear low at an update
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_code   <= MIDCODE;  // [R12]
      latch_update <= 1'b0;
    end else begin
      latch_update <= load_now;
      if (load_now)
        latch_code <= clr_r ? shift_r : MIDCODE;  // [R02] [R03] [R11]
    end
  end

  // the latch moves only in the cycle of an update pulse;
  // the pulse and the new code appear on the same edge
  latch_hold_a: assert property (@(posedge clk)  // [R02]
    disable iff (!rst_n) !latch_update |-> $stable(latch_code))
    else $error("latch moved without an update");

  // clear low at the update gives midcode, not the word
  midcode_clear_a: assert property (@(posedge clk)  // [R11]
    disable iff (!rst_n) (load_now && !clr_r) |=> latch_code == MIDCODE)
    else $error("clear did not give midcode");

  // clear high at the update gives the shifted word;
  // the shift register must not move on the load cycle
  word_load_a: assert property (@(posedge clk)  // [R01]
    disable iff (!rst_n)
    (load_now && clr_r) |=> latch_code == $past(shift_r))
    else $error("shifted word not loaded");

  // output settle timer; a new update restarts the wait
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      settle_r <= '0;
    end else if (load_now) begin
      settle_r <= UPDATE_CYC;  // [R07]
    end else if (settle_r != 8'h00) begin
      settle_r <= settle_r - 8'h01;
    end
  end
  assign output_settled = (settle_r == 8'h00);  // [R07]

  // building blocks of the settle checks: the update pulse,
  // five cycles unsettled, five cycles without a load
  sequence upd_s;
    latch_update;
  endsequence
  sequence settling_s;
    !output_settled [*5];
  endsequence
  sequence quiet_s;
    !load_now [*5];
  endsequence

  // settle flag low for ten cycles from the update pulse;
  // two runs of five keep the repetition short for the tools
  settle_time_a: assert property (@(posedge clk)  // [R07]
    disable iff (!rst_n) upd_s |-> settling_s ##1 settling_s)
    else $error("settled too early");

  // with no new load, settled again right after the ten cycles
  settle_end_a: assert property (@(posedge clk)  // [R07]
    disable iff (!rst_n) load_now ##1 quiet_s ##1 quiet_s |=> output_settled)
    else $error("settle flag late");

endmodule
`default_nettype wire

//--- link_host.sv
// Purpose: host model driving the write-only three-wire link
// Assumes: pins change just after falling clk edges
// Notes:   levels span 8 clk cycles so the pin filter sees every edge
`default_nettype none
module link_host (
  input  wire logic clk,            // bench clock
  output var  logic select_n,       // chip select, active low
  output var  logic bit_clk,        // serial bit clock
  output var  logic serial_data_in  // serial data
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 8;  // clk cycles per bit clock level
  initial begin
    select_n = 1'b1;
    bit_clk = 1'b0;
    serial_data_in = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clk);
  endtask
  // one frame msb first; bits past sixteen are ones
  task automatic send(input logic [15:0] word, input int nbits);
    select_n = 1'b0;
    gap(HALF);
    for (int i = 0; i < nbits; i++) begin
      serial_data_in = (i < 16) ? word[15-i] : 1'b1;
      gap(HALF);
      bit_clk = 1'b1;
      gap(HALF);
      bit_clk = 1'b0;
    end
    gap(HALF);
    select_n = 1'b1;
    // released line must not keep the last bit
    serial_data_in = ~serial_data_in;
    gap(HALF);
  endtask
  // clocks sent while deselected, meant to be ignored
  task automatic idle_clocks(input int n);
    repeat (n) begin
      serial_data_in = ~serial_data_in;
      gap(HALF);
      bit_clk = 1'b1;
      gap(HALF);
      bit_clk = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

//--- serial_dac_input_latch_tb.sv
// Purpose: self-checking bench for the converter input latch
// Assumes: bench inputs change on falling clk edges
// Notes:   frames and update waits run side by side in forks
`default_nettype none
module serial_dac_input_latch_tb;
  import dac_latch_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic              clk, rst_n, force_midcode_n;
  logic              select_n, bit_clk, serial_data_in;
  logic              latch_update, output_settled;
  logic [WORD_W-1:0] latch_code;
  int                error_cnt, check_count, cyc, n;
  logic [15:0]       words [6] = '{16'h7fff, 16'h4000, 16'h0000,
                                   16'hbfff, 16'h8000, 16'ha5c3};
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  link_host host (.clk(clk), .select_n(select_n), .bit_clk(bit_clk),
                  .serial_data_in(serial_data_in));
  dac_input_latch dut (.clk(clk), .rst_n(rst_n), .select_n(select_n),
    .bit_clk(bit_clk), .serial_data_in(serial_data_in),
    .force_midcode_n(force_midcode_n), .latch_code(latch_code),
    .latch_update(latch_update), .output_settled(output_settled));
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // n = cycles of settling low after a load pulse, 0 if none came
  task automatic wait_upd();
    n = 0;
    for (int i = 0; i < 400 && latch_update !== 1'b1; i++) @(negedge clk);
    while (output_settled === 1'b0 && n < 50) begin
      n++;
      @(negedge clk);
    end
  endtask
  task automatic frame(input logic [15:0] w, input int nb,
                       input logic [15:0] exp, input int en);
    fork
      host.send(w, nb);
      wait_upd();
    join
    chk(latch_code, exp);
    chk(16'(n), 16'(en));
  endtask
  task automatic t_reset();
    chk(latch_code, MIDCODE);
    chk({15'h0, output_settled}, 16'h0001);
  endtask
  task automatic t_codes();
    foreach (words[i]) frame(words[i], 16, words[i], 10);
  endtask
  task automatic t_abort();
    frame(16'h1234, 10, 16'ha5c3, 0);
    frame(16'h3c5a, 20, 16'h3c5a, 10);
  endtask
  task automatic t_clear();
    force_midcode_n = 1'b0;
    frame(16'h6789, 16, MIDCODE, 10);
    force_midcode_n = 1'b1;
    frame(16'h6789, 16, 16'h6789, 10);
  endtask
  task automatic t_idle();
    fork
      host.idle_clocks(20);
      wait_upd();
    join
    chk(16'(n), 16'h0000);
    chk(latch_code, 16'h6789);
  endtask
  // reset in mid-run drops the latch back to midcode
  task automatic t_rerst();
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk(latch_code, MIDCODE);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk(latch_code, MIDCODE);
    frame(16'h2468, 16, 16'h2468, 10);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // hang guard, the whole run needs about 3700 cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    rst_n = 1'b0;
    force_midcode_n = 1'b1;
    repeat (4) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_reset();
    t_codes();
    t_abort();
    t_clear();
    t_idle();
    t_rerst();
    final_report();
  end
endmodule
`default_nettype wire
